// >>> verilog/sps_port.sv
`timescale 1ns/1ps
// ==========================================================
// Synchronous serial port, SPI mode
// Notes on behaviour
// - Eight-bit words shift in and out together, MSB first.
// - Completed word moves to buffer, setting buffer-full and port flag.
// - Shift register is reachable only through the buffer register.
// - Buffer-full reads 1 after a receive, clears on buffer read.
// - Buffer write during shifting is dropped and sets write-collision.
// - Slave word arriving onto unread buffer sets overflow, is dropped.
// - Master mode never sets the overflow flag.
// - Port enable hands clock and data pins to the port.
// - Polarity bit gives the clock idle level.
// - Edge bit with polarity picks the data output edge.
// - Master sample phase: end or middle of output time; with edge bit set it always samples in the middle.
// - Codes 0-2 master at clock/4, /16, /64; code 3 timer/2.
// - Code 4 slave with select, code 5 slave ignoring select.
// - Two-wire codes keep the shifting logic inactive.
// - Clock pin output in master, input in slave; rate master only.
// - Start and stop flags read 0 after reset, clear when disabled.
// - Select low drives data-out; select high floats it from the next clock edge.
// - Select high resets the shifting logic in select-controlled slave.
module sps_port
    import sps_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Serial pins
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    input wire logic sdiIn,
    output logic sdoOut,
    output logic sdoOe,
    input wire logic slaveSelN,
    output logic pinsOwned,
    // Internal period timer
    input wire logic timerTick
);

    // ==========================================================
    // State
    typedef struct packed {
        logic waitReq;
        logic [31:0] rdData;
        logic [7:0] ctrl;
        logic input_sample_phase;
        logic cke;
        logic [4:0] twoWire;
        logic bf;
        logic iflag;
        logic [7:0] buffer;
        logic [7:0] sr;
        logic inBit;
        logic [2:0] bitCnt;
        logic busy;
        sps_phase_t phase;
        logic sck;
        logic sckOe;
        logic sdoOe;
        logic owned;
    } sps_core_t;

    sps_core_t s;
    sps_core_t n;

    sps_kind_t kind;
    logic isMaster;
    logic isSlave;
    logic ssHigh;
    logic clock_idle_polarity;
    logic lead;
    logic trail;
    logic done;
    logic [7:0] srNew;
    logic [7:0] wd;
    logic [7:0] ctrlWr;
    logic wrNow;
    logic rdNow;
    logic wcolSet;
    logic ovSet;
    logic bfSet;
    logic iflagSet;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction : hit

    function automatic logic [7:0] regVal(input sps_core_t st,
                                          input logic [ADDR_W-1:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (hit(a, SPS_OFS_BUF))
        begin
            v = st.buffer;
        end
        else if (hit(a, SPS_OFS_CTRL))
        begin
            v = st.ctrl;
        end
        else if (hit(a, SPS_OFS_STAT))
        begin
            v = {st.input_sample_phase, st.cke, st.twoWire, st.bf};
        end
        else if (hit(a, SPS_OFS_IFLAG))
        begin
            v = {7'h00, st.iflag};
        end
        return v;
    endfunction : regVal

    // ==========================================================
    // Helpers
    sps_link_if lnk();

    // Decoded apart from next state: keeps the rate link free of a loop
    assign kind = sps_kind(s.ctrl[SPS_CTRL_EN], s.ctrl[SPS_CTRL_MODE_HI:0]);
    assign isMaster = (kind == SPS_KIND_MASTER);
    assign isSlave = (kind == SPS_KIND_SLAVE_SS) ||
                     (kind == SPS_KIND_SLAVE_FREE);
    assign ssHigh = (kind == SPS_KIND_SLAVE_SS) && slaveSelN;

    assign lnk.run = isMaster && (s.phase == SPS_SHIFT);
    assign lnk.rateSel = s.ctrl[1:0];
    assign lnk.timerTick = timerTick;
    assign lnk.sckIn = sckIn;

    sps_rate_gen #(
        .CNT_W(5)
    ) u_rate (
        .core_clk(core_clk),
        .rst(rst),
        .lnk(lnk.rate)
    );

    sps_sck_edge u_edge (
        .core_clk(core_clk),
        .rst(rst),
        .lnk(lnk.sense)
    );

    // ==========================================================
    // Next state
    always_comb
    begin
        n = s;
        clock_idle_polarity = s.ctrl[SPS_CTRL_CKP];
        lead = 1'b0;
        trail = 1'b0;
        done = 1'b0;
        srNew = s.sr;
        wd = avs_writedata[7:0];
        wrNow = avs_write && !s.waitReq && avs_byteenable[0];
        rdNow = avs_read && !s.waitReq;
        wcolSet = 1'b0;
        ovSet = 1'b0;
        bfSet = 1'b0;
        iflagSet = 1'b0;

        // Bus handshake: one wait cycle, then answer
        if (!s.waitReq)
        begin
            n.waitReq = 1'b1;
        end
        else if (avs_read || avs_write)
        begin
            n.waitReq = 1'b0;
            n.rdData = avs_read ? {24'h000000, regVal(s, avs_address)}
                                : 32'h00000000;
        end

        // Clock events: own divided clock or the peer's pin
        if (isMaster && s.phase == SPS_SHIFT && lnk.halfTick)
        begin
            n.sck = !s.sck;
            lead = (s.sck == clock_idle_polarity);
            trail = (s.sck != clock_idle_polarity);
        end
        else if (isSlave && !ssHigh)
        begin
            lead = clock_idle_polarity ? lnk.sckFall : lnk.sckRise;
            trail = clock_idle_polarity ? lnk.sckRise : lnk.sckFall;
        end
        if (lead || trail)
        begin
            n.busy = 1'b1;
        end

        // Edge bit set: data moves on the leading edge
        if (s.cke)
        begin
            if (lead && s.bitCnt != 3'h0)
            begin
                srNew = {s.sr[6:0], s.inBit};
            end
            if (trail)
            begin
                n.inBit = sdiIn;
                if (s.bitCnt == 3'h7)
                begin
                    srNew = {s.sr[6:0], sdiIn};
                    done = 1'b1;
                end
            end
        end
        else
        begin
            if (lead)
            begin
                n.inBit = sdiIn;
            end
            if (trail)
            begin
                // Late sampling picks the pin up right at the shift
                srNew = {s.sr[6:0],
                         (s.input_sample_phase && isMaster) ? sdiIn : s.inBit};
                done = (s.bitCnt == 3'h7);
            end
        end
        if (trail)
        begin
            n.bitCnt = s.bitCnt + 3'h1;
        end
        n.sr = srNew;

        // Word complete
        if (done)
        begin
            n.busy = 1'b0;
            n.phase = SPS_IDLE;
            if (isSlave && s.bf)
            begin
                ovSet = 1'b1;
            end
            else
            begin
                n.buffer = srNew;
                bfSet = 1'b1;
                iflagSet = 1'b1;
            end
        end

        // Buffer write loads the shift register
        if (wrNow && hit(avs_address, SPS_OFS_BUF))
        begin
            if (s.busy)
            begin
                wcolSet = 1'b1;
            end
            else
            begin
                n.sr = wd;
                n.buffer = wd;
                n.bitCnt = 3'h0;
                if (isMaster)
                begin
                    n.phase = SPS_SHIFT;
                    n.busy = 1'b1;
                end
            end
        end

        // Control: hardware sets win over a software clear
        ctrlWr = s.ctrl;
        if (wrNow && hit(avs_address, SPS_OFS_CTRL))
        begin
            ctrlWr = wd;
        end
        n.ctrl = ctrlWr;
        n.ctrl[SPS_CTRL_WRITE_COLLISION_FLAG] = ctrlWr[SPS_CTRL_WRITE_COLLISION_FLAG] || wcolSet;
        // Master completions never reach ovSet
        n.ctrl[SPS_CTRL_OV] = ctrlWr[SPS_CTRL_OV] || ovSet;

        // Status: only phase and edge bits are writable
        if (wrNow && hit(avs_address, SPS_OFS_STAT))
        begin
            n.input_sample_phase = wd[SPS_STAT_SMP];
            n.cke = wd[SPS_STAT_CKE];
        end
        n.bf = (s.bf && !(rdNow && hit(avs_address, SPS_OFS_BUF)))
               || bfSet;

        n.iflag = s.iflag;
        if (wrNow && hit(avs_address, SPS_OFS_IFLAG))
        begin
            n.iflag = wd[0];
        end
        n.iflag = n.iflag || iflagSet;

        // Inactive modes and deselect hold the shifter reset
        if (!(isMaster || isSlave) || ssHigh)
        begin
            n.busy = 1'b0;
            n.bitCnt = 3'h0;
            n.phase = SPS_IDLE;
            n.inBit = 1'b0;
        end
        if (n.phase == SPS_IDLE)
        begin
            n.sck = n.ctrl[SPS_CTRL_CKP];
        end

        // Two-wire flags stay still; disable clears them
        if (!s.ctrl[SPS_CTRL_EN])
        begin
            n.twoWire = 5'h00;
        end

        // Pin ownership
        n.owned = s.ctrl[SPS_CTRL_EN];
        n.sckOe = isMaster;
        n.sdoOe = isMaster || (kind == SPS_KIND_SLAVE_FREE) ||
                  ((kind == SPS_KIND_SLAVE_SS) && !slaveSelN);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.waitReq <= 1'b1;
            s.ctrl <= SPS_CTRL_RST;
            {s.input_sample_phase, s.cke, s.twoWire, s.bf} <= SPS_STAT_RST;
            s.phase <= SPS_IDLE;
        end
        else
        begin
            s <= n;
        end
    end

    // ==========================================================
    // Outputs, all straight from flops
    assign avs_readdata = s.rdData;
    assign avs_waitrequest = s.waitReq;
    assign sckOut = s.sck;
    assign sckOe = s.sckOe;
    assign sdoOut = s.sr[7];
    assign sdoOe = s.sdoOe;
    assign pinsOwned = s.owned;

endmodule : sps_port

// >>> verilog/sps_pkg.sv
package sps_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] SPS_OFS_BUF = 8'h10;
    localparam logic [7:0] SPS_OFS_CTRL = 8'h14;
    localparam logic [7:0] SPS_OFS_IFLAG = 8'h18;
    localparam logic [7:0] SPS_OFS_STAT = 8'h94;

    // ==========================================================
    // Field positions and reset values
    localparam int SPS_CTRL_WRITE_COLLISION_FLAG = 7;
    localparam int SPS_CTRL_OV = 6;
    localparam int SPS_CTRL_EN = 5;
    localparam int SPS_CTRL_CKP = 4;
    localparam int SPS_CTRL_MODE_HI = 3;
    localparam int SPS_STAT_SMP = 7;
    localparam int SPS_STAT_CKE = 6;
    localparam int SPS_STAT_BF = 0;
    localparam logic [7:0] SPS_CTRL_RST = 8'h00;
    localparam logic [7:0] SPS_STAT_RST = 8'h00;

    // ==========================================================
    // Mode codes
    localparam logic [3:0] SPS_MODE_DIV4 = 4'h0;
    localparam logic [3:0] SPS_MODE_DIV16 = 4'h1;
    localparam logic [3:0] SPS_MODE_DIV64 = 4'h2;
    localparam logic [3:0] SPS_MODE_TIMER = 4'h3;
    localparam logic [3:0] SPS_MODE_SLAVE_SS = 4'h4;
    localparam logic [3:0] SPS_MODE_SLAVE_FREE = 4'h5;

    // Bit periods in core clocks
    localparam int SPS_DIV_FAST = 4;
    localparam int SPS_DIV_MID = 16;
    localparam int SPS_DIV_SLOW = 64;

    typedef enum logic [2:0] {
        SPS_KIND_OFF,
        SPS_KIND_MASTER,
        SPS_KIND_SLAVE_SS,
        SPS_KIND_SLAVE_FREE,
        SPS_KIND_TWO_WIRE
    } sps_kind_t;

    typedef enum logic {
        SPS_IDLE,
        SPS_SHIFT
    } sps_phase_t;

    function automatic sps_kind_t sps_kind(input logic en,
                                           input logic [3:0] mode);
        sps_kind_t k;
        k = SPS_KIND_TWO_WIRE;
        case (mode)
            SPS_MODE_DIV4, SPS_MODE_DIV16,
            SPS_MODE_DIV64, SPS_MODE_TIMER: k = SPS_KIND_MASTER;
            SPS_MODE_SLAVE_SS: k = SPS_KIND_SLAVE_SS;
            SPS_MODE_SLAVE_FREE: k = SPS_KIND_SLAVE_FREE;
            default: k = SPS_KIND_TWO_WIRE;
        endcase
        if (!en)
        begin
            k = SPS_KIND_OFF;
        end
        return k;
    endfunction : sps_kind

endpackage : sps_pkg

// >>> verilog/sps_link_if.sv
`timescale 1ns/1ps
interface sps_link_if;
    logic run;
    logic [1:0] rateSel;
    logic timerTick;
    logic halfTick;
    logic sckIn;
    logic sckRise;
    logic sckFall;
    modport core(output run, rateSel, timerTick, sckIn,
                 input halfTick, sckRise, sckFall);
    modport rate(input run, rateSel, timerTick, output halfTick);
    modport sense(input sckIn, output sckRise, sckFall);
endinterface : sps_link_if

// >>> verilog/sps_rate_gen.sv
`timescale 1ns/1ps
module sps_rate_gen
    import sps_pkg::*;
#(
    parameter int CNT_W = 5
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Link to core
    sps_link_if.rate lnk
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } sps_rate_t;

    sps_rate_t s;
    sps_rate_t n;
    logic [CNT_W-1:0] last;

    // Half a bit period per tick; timer mode halves the timer rate
    always_comb
    begin
        case (lnk.rateSel)
            2'h0: last = CNT_W'(SPS_DIV_FAST / 2 - 1);
            2'h1: last = CNT_W'(SPS_DIV_MID / 2 - 1);
            default: last = CNT_W'(SPS_DIV_SLOW / 2 - 1);
        endcase
        n = s;
        if (!lnk.run || s.cnt == last)
        begin
            n.cnt = '0;
        end
        else
        begin
            n.cnt = s.cnt + CNT_W'(1);
        end
    end

    assign lnk.halfTick = lnk.run && ((lnk.rateSel == 2'h3) ?
                          lnk.timerTick : (s.cnt == last));

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

endmodule : sps_rate_gen

// >>> verilog/sps_sck_edge.sv
`timescale 1ns/1ps
module sps_sck_edge
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Link to core
    sps_link_if.sense lnk
);

    typedef struct packed {
        logic prev;
    } sps_edge_t;

    sps_edge_t s;
    sps_edge_t n;

    always_comb
    begin
        n = s;
        n.prev = lnk.sckIn;
    end

    assign lnk.sckRise = lnk.sckIn && !s.prev;
    assign lnk.sckFall = !lnk.sckIn && s.prev;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

endmodule : sps_sck_edge

// >>> sim/sps_port_properties.sv
`timescale 1ns/1ps
module sps_port_properties
    import sps_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Bus
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pins
    input wire logic sckOut,
    input wire logic sckOe,
    input wire logic sdoOe,
    input wire logic slaveSelN,
    input wire logic pinsOwned
);
    // ==========================================================
    // Control mirror, taken at the completing edge of a write
    logic [7:0] ctl;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            ctl <= 8'h00;
        else if (avs_write && !avs_waitrequest
                 && avs_address == SPS_OFS_CTRL)
            ctl <= avs_writedata[7:0];
    end
    wire en = ctl[SPS_CTRL_EN];
    wire [3:0] md = ctl[3:0];
    wire mst = en && md < 4'h4;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // ==========================================================
    // Properties
    a_wait_one:
    assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("Bus answer late");
    a_wait_back:
    assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Wait low too long");
    a_upper_zero:
    assert property (avs_readdata[31:8] == 24'h0)
        else $error("Read data upper bits set");
    a_pins_taken:
    assert property (en ##1 en |-> pinsOwned)
        else $error("Pins not owned while enabled");
    a_pins_freed:
    assert property (!en ##1 !en |-> !pinsOwned && !sckOe && !sdoOe)
        else $error("Pins held while disabled");
    a_sck_master:
    assert property (mst ##1 mst |-> sckOe)
        else $error("Clock not driven in master");
    a_sck_input:
    assert property (!mst ##1 !mst |-> !sckOe)
        else $error("Clock driven outside master");
    a_sel_float:
    assert property (en && md == SPS_MODE_SLAVE_SS && slaveSelN ##1
        en && md == SPS_MODE_SLAVE_SS && slaveSelN |-> !sdoOe)
        else $error("Data out driven while deselected");
    a_rate_fast:
    assert property (mst && md == SPS_MODE_DIV4 && $changed(sckOut)
        |=> $stable(sckOut)) else $error("Fast clock half wrong");
    a_rate_mid:
    assert property (mst && md == SPS_MODE_DIV16 && $changed(sckOut)
        |=> $stable(sckOut)[*7]) else $error("Mid clock half wrong");
    a_two_wire:
    assert property (en && md >= 4'h6 ##1 en && md >= 4'h6
        |-> !sckOe && !sdoOe) else $error("Shifter active in two-wire");
endmodule : sps_port_properties

bind sps_port sps_port_properties #(.ADDR_W(ADDR_W)) sps_port_properties_i (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sckOut(sckOut), .sckOe(sckOe),
    .sdoOe(sdoOe), .slaveSelN(slaveSelN), .pinsOwned(pinsOwned));

// >>> sim/sps_peer.sv
`timescale 1ns/1ps
module sps_peer
(
    // Clock
    input wire logic core_clk,
    // Link
    input wire logic sckLine,
    input wire logic clock_idle_polarity,
    input wire logic sdoOut,
    output logic sdi,
    // Control
    input wire logic restart,
    input wire logic [7:0] txByte,
    output logic [7:0] rxByte
);
    logic prev;
    logic [7:0] sh;
    // Lead edge samples, trail edge shifts, MSB first
    always @(posedge core_clk)
    begin
        prev <= sckLine;
        if (restart)
        begin
            sh <= txByte;
            sdi <= txByte[7];
        end
        else if (sckLine !== prev && sckLine !== clock_idle_polarity)
            rxByte <= {rxByte[6:0], sdoOut};
        else if (sckLine !== prev)
        begin
            // Spent bits refill with a changing pattern
            sh <= {sh[6:0], ~sh[0]};
            sdi <= sh[6];
        end
    end
endmodule : sps_peer

// >>> sim/sps_port_bench.sv
`timescale 1ns/1ps
module sps_port_bench;
    import sps_pkg::*;
    logic core_clk = 0, rst = 1, avs_read = 0, avs_write = 0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic avs_waitrequest, sckOut, sckOe, sdiIn, sdoOut, sdoOe;
    logic slaveSelN = 1, pinsOwned, timerTick = 0, sckB = 0, clock_idle_polarity = 0;
    logic tickOn = 0, peerLoad = 0;
    logic [7:0] peerTx = 8'h00, peerRx;
    wire sckIn = sckOe ? sckOut : sckB;
    int bad_count = 0, samples_checked = 0, cyc = 0, togs = 0, lastTog;
    logic sckPrev = 0;

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        timerTick <= tickOn && cyc[1:0] == 2'h0;
        sckPrev <= sckOut;
        if (sckOut !== sckPrev)
        begin
            togs <= togs + 1;
            lastTog <= cyc;
        end
    end

    sps_port sps_port_i (.core_clk(core_clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sckIn(sckIn),
        .sckOut(sckOut), .sckOe(sckOe), .sdiIn(sdiIn), .sdoOut(sdoOut),
        .sdoOe(sdoOe), .slaveSelN(slaveSelN), .pinsOwned(pinsOwned),
        .timerTick(timerTick));
    sps_peer sps_peer_i (.core_clk(core_clk), .sckLine(sckIn),
        .clock_idle_polarity(clock_idle_polarity), .sdoOut(sdoOe ? sdoOut : !sdoOut), .sdi(sdiIn),
        .restart(peerLoad),
        .txByte(peerTx), .rxByte(peerRx));

    // ==========================================================
    // Shared tasks
    task test_done;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
             output logic [7:0] q);
        int n;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0)
        begin
            bad_count++;
            test_done;
        end
        q = avs_readdata[7:0];
        avs_write <= 0;
        avs_read <= 0;
    endtask : bus

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1, a, d, q);
    endtask : wr

    task rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(0, a, 8'h00, q);
        chk({24'h0, q}, {24'h0, exp});
    endtask : rdchk

    task wait_bf;
        logic [7:0] q;
        int n;
        n = 0;
        do
        begin
            bus(0, SPS_OFS_STAT, 8'h00, q);
            n++;
        end
        while (q[SPS_STAT_BF] !== 1'b1 && n < 200);
        if (q[SPS_STAT_BF] !== 1'b1)
        begin
            bad_count++;
            test_done;
        end
    endtask : wait_bf

    task load_peer(input logic [7:0] d);
        peerTx <= d;
        peerLoad <= 1;
        @(posedge core_clk);
        peerLoad <= 0;
    endtask : load_peer

    task slv_bits(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge core_clk);
            sckB <= 1;
            repeat (4) @(posedge core_clk);
            sckB <= 0;
        end
        repeat (6) @(posedge core_clk);
    endtask : slv_bits

    // ==========================================================
    // Scenarios
    task t_reset;
        rdchk(SPS_OFS_CTRL, SPS_CTRL_RST);
        rdchk(SPS_OFS_STAT, SPS_STAT_RST);
        rdchk(8'h40, 8'h00);
        wr(SPS_OFS_STAT, 8'hff);
        rdchk(SPS_OFS_STAT, 8'hc0);
        wr(SPS_OFS_STAT, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task t_master(input logic [3:0] m, input logic p, input int h,
                  input logic [7:0] st);
        int b, s;
        logic [7:0] c;
        c = {3'h1, p, m};
        clock_idle_polarity <= p;
        wr(SPS_OFS_STAT, st);
        wr(SPS_OFS_CTRL, c);
        load_peer(8'h3c);
        // Pin ownership shows one edge after the control write
        @(posedge core_clk);
        chk(pinsOwned, 1);
        b = togs;
        wr(SPS_OFS_BUF, 8'ha5);
        s = cyc;
        // Second write lands mid-word and must be dropped
        wr(SPS_OFS_BUF, 8'h11);
        rdchk(SPS_OFS_CTRL, c | 8'h80);
        wait_bf;
        chk(togs - b, 16);
        chk(sckOut, p);
        chk(32'(lastTog - s > 16 * h - 4 && lastTog - s < 16 * h + 4), 1);
        chk(peerRx, 8'ha5);
        rdchk(SPS_OFS_BUF, 8'h3c);
        rdchk(SPS_OFS_STAT, st);
        wr(SPS_OFS_CTRL, c);
        rdchk(SPS_OFS_CTRL, c);
        $display("test master mode %0d done", m);
    endtask : t_master

    task t_slave;
        clock_idle_polarity <= 0;
        wr(SPS_OFS_STAT, 8'h00);
        wr(SPS_OFS_CTRL, 8'h24);
        wr(SPS_OFS_BUF, 8'hc3);
        slaveSelN <= 0;
        load_peer(8'h96);
        repeat (3) @(posedge core_clk);
        chk(sdoOe, 1);
        slv_bits(8);
        rdchk(SPS_OFS_STAT, 8'h01);
        chk(peerRx, 8'hc3);
        load_peer(8'h69);
        slv_bits(8);
        rdchk(SPS_OFS_CTRL, 8'h64);
        rdchk(SPS_OFS_BUF, 8'h96);
        wr(SPS_OFS_CTRL, 8'h24);
        load_peer(8'h33);
        slv_bits(3);
        slaveSelN <= 1;
        repeat (3) @(posedge core_clk);
        chk(sdoOe, 0);
        slaveSelN <= 0;
        load_peer(8'h5a);
        slv_bits(8);
        rdchk(SPS_OFS_BUF, 8'h5a);
        // Select ignored: data out driven although select is high
        slaveSelN <= 1;
        wr(SPS_OFS_CTRL, 8'h25);
        repeat (2) @(posedge core_clk);
        chk(sdoOe, 1);
        $display("test slave done");
    endtask : t_slave

    task t_off;
        int b;
        wr(SPS_OFS_CTRL, 8'h26);
        b = togs;
        wr(SPS_OFS_BUF, 8'h55);
        repeat (40) @(posedge core_clk);
        chk(togs - b, 0);
        chk(sckOe, 0);
        wr(SPS_OFS_CTRL, 8'h00);
        repeat (3) @(posedge core_clk);
        chk(pinsOwned, 0);
        rdchk(SPS_OFS_STAT, 8'h00);
        $display("test two-wire and disable done");
    endtask : t_off

    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 0;
        t_reset;
        t_master(SPS_MODE_DIV4, 0, SPS_DIV_FAST / 2, 8'h00);
        t_master(SPS_MODE_DIV16, 1, SPS_DIV_MID / 2, 8'h80);
        t_master(SPS_MODE_DIV64, 0, SPS_DIV_SLOW / 2, 8'h00);
        tickOn <= 1;
        t_master(SPS_MODE_TIMER, 1, 4, 8'h00);
        t_slave;
        t_off;
        test_done;
    end

    // Hang guard
    initial
    begin
        repeat (90000) @(posedge core_clk);
        bad_count++;
        test_done;
    end
endmodule : sps_port_bench
